/* design/step_attenuator_serial_control.sv */
`timescale 1ns/1ps
module step_attenuator_serial_control
   import step_atten_pkg::*;
(
   // system
   input wire logic REF_CLK,
   input wire logic RESET,
   // serial port
   input wire logic SERIAL_CLK,
   input wire logic SERIAL_DATA,
   input wire logic LATCH_STROBE,
   // chip id pins and fast switch select
   input wire logic CHIP_ID_PIN_BIT0,
   input wire logic CHIP_ID_PIN_BIT1,
   input wire logic CHIP_ID_PIN_BIT2,
   input wire logic FAST_SWITCH_SELECT,
   // attenuator core stage controls
   output logic [6:0] STAGE_CONTROL
);
   // all pins but RESET are sampled on REF_CLK; the serial clock must stay below a quarter of it
   logic [5:0] s1_reg, s2_reg, s1_next, s2_next;
   logic sck_d_reg, latch_d_reg, sck_d_next, latch_d_next;
   logic [FRAME_BITS-1:0] shift_reg, shift_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic armed_reg, armed_next;
   logic [7:0] primary_reg, primary_next;
   logic [7:0] config_reg, config_next;
   logic [7:0] preset_reg, preset_next;
   logic [6:0] stage_reg, stage_next;
   logic sck, sdi, latch, sel;
   logic [2:0] chip_id;
   logic id_match, write_fire;

   // the first stage is read by nothing but the second, to keep metastability contained
   always_comb
   begin
      s1_next = {FAST_SWITCH_SELECT, CHIP_ID_PIN_BIT2, CHIP_ID_PIN_BIT1,
                 CHIP_ID_PIN_BIT0, LATCH_STROBE, SERIAL_CLK};
      s2_next = s1_reg;
      sck_d_next = s2_reg[0];
      latch_d_next = s2_reg[1];
   end

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         s1_reg <= 6'h00;
         s2_reg <= 6'h00;
         sck_d_reg <= 1'b0;
         latch_d_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         sck_d_reg <= sck_d_next;
         latch_d_reg <= latch_d_next;
      end
   end

   assign sck = s2_reg[0];
   assign latch = s2_reg[1];
   // id pins reflect the board; internal pulls give 6 when floating
   assign chip_id = s2_reg[4:2];
   assign sel = s2_reg[5];

   // data pin needs only to settle at serial clock edges, so a shift copy is taken
   logic sdi_s1_reg, sdi_s2_reg, sdi_s1_next, sdi_s2_next;
   always_comb
   begin
      sdi_s1_next = SERIAL_DATA;
      sdi_s2_next = sdi_s1_reg;
   end

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         sdi_s1_reg <= 1'b0;
         sdi_s2_reg <= 1'b0;
      end
      else
      begin
         sdi_s1_reg <= sdi_s1_next;
         sdi_s2_reg <= sdi_s2_next;
      end
   end
   assign sdi = sdi_s2_reg;

   // chip id and reserved bit
   assign id_match = (shift_reg[ADDR_ID_LSB +: 3] == chip_id) && !shift_reg[ADDR_RSV_BIT];
   assign write_fire = armed_reg && latch_d_reg && !latch;

   always_comb
   begin
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      armed_next = armed_reg;
      primary_next = primary_reg;
      config_next = config_reg;
      preset_next = preset_reg;
      if (!latch && sck && !sck_d_reg)
      begin
         // lsb first: bits enter at the top, first bit ends at bit 0
         shift_next = {sdi, shift_reg[FRAME_BITS-1:1]};
         if (cnt_reg != CNT_W'(FRAME_BITS))
            cnt_next = cnt_reg + CNT_W'(1);
      end
      if (latch && !latch_d_reg)
         armed_next = (cnt_reg == CNT_W'(FRAME_BITS)) && id_match;
      if (write_fire)
      begin
         armed_next = 1'b0;
         cnt_next = '0;
         case (shift_reg[ADDR_REG_LSB +: 4])
            REG_PRIMARY: primary_next = shift_reg[7:0];
            REG_CONFIG: config_next = shift_reg[7:0];
            REG_PRESET: preset_next = shift_reg[7:0];
            default: ;
         endcase
      end
      else if (!latch && latch_d_reg)
         cnt_next = '0;
   end

   // stage word: bit 7 dropped, bits map to weighted cells
   always_comb
   begin
      if (config_reg[CFG_ENABLE_BIT] && !config_reg[CFG_POINTER_BIT] && sel)
         stage_next = preset_reg[ATTEN_MSB:0];
      else
         stage_next = primary_reg[ATTEN_MSB:0];
   end

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         shift_reg <= '0;
         cnt_reg <= '0;
         armed_reg <= 1'b0;
         primary_reg <= PRIMARY_RESET;
         config_reg <= CONFIG_RESET;
         preset_reg <= PRESET_RESET;
         stage_reg <= PRIMARY_RESET[ATTEN_MSB:0];
      end
      else
      begin
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         armed_reg <= armed_next;
         primary_reg <= primary_next;
         config_reg <= config_next;
         preset_reg <= preset_next;
         stage_reg <= stage_next;
      end
   end

   assign STAGE_CONTROL = stage_reg;

   sequence fire_s;
      write_fire && shift_reg[ADDR_REG_LSB +: 4] == REG_PRIMARY;
   endsequence

   a_primary_write: assert property (@(posedge REF_CLK) disable iff (RESET)
      fire_s |=> primary_reg == $past(shift_reg[7:0]))
      else $error("primary word not written");
   a_preset_write: assert property (@(posedge REF_CLK) disable iff (RESET)
      write_fire && shift_reg[ADDR_REG_LSB +: 4] == REG_PRESET
      |=> preset_reg == $past(shift_reg[7:0]))
      else $error("preset word not written");
   a_config_write: assert property (@(posedge REF_CLK) disable iff (RESET)
      write_fire && shift_reg[ADDR_REG_LSB +: 4] == REG_CONFIG
      |=> config_reg == $past(shift_reg[7:0]))
      else $error("config not written");
   a_mismatch_drop: assert property (@(posedge REF_CLK) disable iff (RESET)
      latch && !latch_d_reg && !id_match |=> !armed_reg)
      else $error("mismatched frame armed");
   a_no_fire_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
      !write_fire |=> $stable(primary_reg) && $stable(preset_reg) && $stable(config_reg))
      else $error("register changed without latch");
   a_preset_route: assert property (@(posedge REF_CLK) disable iff (RESET)
      config_reg[CFG_ENABLE_BIT] && !config_reg[CFG_POINTER_BIT] && sel
      |=> STAGE_CONTROL == $past(preset_reg[ATTEN_MSB:0]))
      else $error("preset not routed");
   a_disabled_primary: assert property (@(posedge REF_CLK) disable iff (RESET)
      !config_reg[CFG_ENABLE_BIT] |=> STAGE_CONTROL == $past(primary_reg[ATTEN_MSB:0]))
      else $error("select pin acted while disabled");
   a_count_bound: assert property (@(posedge REF_CLK) disable iff (RESET)
      cnt_reg <= CNT_W'(FRAME_BITS))
      else $error("bit count overrun");
   a_reset_max: assert property (@(posedge REF_CLK)
      $fell(RESET) |-> STAGE_CONTROL == PRIMARY_RESET[ATTEN_MSB:0])
      else $error("reset attenuation not maximum");

   // receive steps: bit shifted, strobe raised, strobe dropped, frame full
   sequence shift_edge_s;
      !latch && sck && !sck_d_reg;
   endsequence

   sequence latch_rise_s;
      latch && !latch_d_reg;
   endsequence

   sequence latch_fall_s;
      !latch && latch_d_reg;
   endsequence

   sequence full_frame_s;
      cnt_reg == CNT_W'(FRAME_BITS);
   endsequence

   a_lsb_shift: assert property (@(posedge REF_CLK) disable iff (RESET)
      shift_edge_s
      |=> shift_reg == {$past(sdi), $past(shift_reg[FRAME_BITS-1:1])})
      else $error("serial bit not shifted in at the top");

   a_count_step: assert property (@(posedge REF_CLK) disable iff (RESET)
      shift_edge_s ##0 (!latch_d_reg && cnt_reg != CNT_W'(FRAME_BITS))
      |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
      else $error("bit count did not step");

   a_count_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
      shift_edge_s ##0 full_frame_s ##0 !latch_d_reg
      |=> cnt_reg == CNT_W'(FRAME_BITS))
      else $error("bit count did not saturate");

   a_count_clear: assert property (@(posedge REF_CLK) disable iff (RESET)
      latch_fall_s
      |=> cnt_reg == '0)
      else $error("bit count not cleared at strobe fall");

   a_arm_full: assert property (@(posedge REF_CLK) disable iff (RESET)
      latch_rise_s ##0 full_frame_s ##0 id_match
      |=> armed_reg)
      else $error("matching full frame not armed");

   a_arm_short: assert property (@(posedge REF_CLK) disable iff (RESET)
      latch_rise_s ##0 cnt_reg != CNT_W'(FRAME_BITS)
      |=> !armed_reg)
      else $error("short frame armed");

   a_reserved_drop: assert property (@(posedge REF_CLK) disable iff (RESET)
      latch_rise_s ##0 shift_reg[ADDR_RSV_BIT]
      |=> !armed_reg)
      else $error("frame with reserved bit set armed");

   a_fire_disarm: assert property (@(posedge REF_CLK) disable iff (RESET)
      write_fire
      |=> !armed_reg && cnt_reg == '0)
      else $error("receiver not idle after write");

   a_unused_addr: assert property (@(posedge REF_CLK) disable iff (RESET)
      write_fire && shift_reg[ADDR_REG_LSB +: 4] > REG_PRESET
      |=> $stable(primary_reg) && $stable(config_reg) && $stable(preset_reg))
      else $error("unused register address changed state");

   a_shift_quiet: assert property (@(posedge REF_CLK) disable iff (RESET)
      latch
      |=> $stable(shift_reg))
      else $error("shifted while strobe high");

   a_armed_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
      armed_reg && !write_fire && !(latch && !latch_d_reg)
      |=> armed_reg)
      else $error("armed frame lost before strobe fall");

   a_no_arm_write: assert property (@(posedge REF_CLK) disable iff (RESET)
      !armed_reg
      |=> $stable(primary_reg) && $stable(config_reg) && $stable(preset_reg))
      else $error("register written without armed frame");

   // reset checks carry no disable so that they see the release edge
   a_reset_receiver: assert property (@(posedge REF_CLK)
      $fell(RESET)
      |-> cnt_reg == '0 && !armed_reg)
      else $error("receiver not idle after reset");

   a_reset_defaults: assert property (@(posedge REF_CLK)
      $fell(RESET)
      |-> config_reg == CONFIG_RESET && preset_reg == PRESET_RESET && primary_reg == PRIMARY_RESET)
      else $error("register defaults not restored");

   a_pointer_primary: assert property (@(posedge REF_CLK) disable iff (RESET)
      config_reg[CFG_ENABLE_BIT] && config_reg[CFG_POINTER_BIT]
      |=> STAGE_CONTROL == $past(primary_reg[ATTEN_MSB:0]))
      else $error("pointer flag set but preset routed");

   a_select_low: assert property (@(posedge REF_CLK) disable iff (RESET)
      config_reg[CFG_ENABLE_BIT] && !sel
      |=> STAGE_CONTROL == $past(primary_reg[ATTEN_MSB:0]))
      else $error("select low but primary not routed");

   a_select_follow: assert property (@(posedge REF_CLK) disable iff (RESET)
      $changed(sel) && config_reg[CFG_ENABLE_BIT] && !config_reg[CFG_POINTER_BIT]
      |=> STAGE_CONTROL == $past(sel ? preset_reg[ATTEN_MSB:0] : primary_reg[ATTEN_MSB:0]))
      else $error("select change not followed");

   a_two_words: assert property (@(posedge REF_CLK) disable iff (RESET)
      1'b1
      |=> STAGE_CONTROL == $past(primary_reg[ATTEN_MSB:0]) || STAGE_CONTROL == $past(preset_reg[ATTEN_MSB:0]))
      else $error("stage word from neither stored word");
endmodule : step_attenuator_serial_control

/* design/step_atten_pkg.sv */
// Summary of operation
// - seven binary-weighted stages, bit 7 ignored
// - reset applies maximum attenuation, all seven set
// - register 0 write updates primary word
// - reset clears configuration, fast switch off
// - configuration bit 1 enables or disables feature
// - bit 0 zero selects preset on high pin
// - preset defaults maximum, replaced by register 2 write
// - enabled, bit 0 zero and pin high selects preset word
// - feature disabled, select pin has no effect
// - floating id pins give chip address 6
// - lsb first, data byte then address byte
// - address byte: id 2:0, reserved 3, register 7:4
// - latch strobe high compares, falling edge writes
// - chip id mismatch discards the frame
package step_atten_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CNT_W = 5;
   localparam logic [3:0] REG_PRIMARY = 4'h0;
   localparam logic [3:0] REG_CONFIG = 4'h1;
   localparam logic [3:0] REG_PRESET = 4'h2;
   localparam logic [7:0] PRIMARY_RESET = 8'h7f;
   localparam logic [7:0] PRESET_RESET = 8'h7f;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam int CFG_ENABLE_BIT = 1;
   localparam int CFG_POINTER_BIT = 0;
   localparam int ATTEN_MSB = 6;
   localparam int ADDR_REG_LSB = 12;
   localparam int ADDR_RSV_BIT = 11;
   localparam int ADDR_ID_LSB = 8;
   localparam logic [2:0] FLOAT_CHIP_ID = 3'h6;
endpackage : step_atten_pkg

/* test/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
   // serial port toward the device
   input wire logic clk,
   output logic sck,
   output logic sdi,
   output logic latch_strobe
);
   initial
   begin
      sck = 1'b0;
      sdi = 1'b0;
      latch_strobe = 1'b0;
   end
   // four cycles per phase keeps each level well past the device's two-stage sync
   task automatic send(input logic [3:0] rg, input logic rsv, input logic [2:0] id,
                       input logic [7:0] d);
      logic [15:0] f;
      f = {rg, rsv, id, d};
      for (int i = 0; i < 16; i++)
      begin
         sdi <= f[i];
         repeat (4) @(posedge clk);
         sck <= 1'b1;
         repeat (4) @(posedge clk);
         sck <= 1'b0;
      end
      sdi <= ~sdi;
      repeat (4) @(posedge clk);
      latch_strobe <= 1'b1;
      repeat (4) @(posedge clk);
      latch_strobe <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : send
endmodule : spi_host_model

/* test/tb_step_attenuator_serial_control.sv */
`timescale 1ns/1ps
module tb_step_attenuator_serial_control;
   import step_atten_pkg::*;
   logic ref_clk, reset, sck, sdi, latch_strobe, sel, mon_on;
   logic [2:0] id;
   logic [6:0] stage, cur, v;
   logic [6:0] exp_q[$];
   int err_total, n_compared, seed;
   step_attenuator_serial_control u_dut (.REF_CLK(ref_clk), .RESET(reset),
      .SERIAL_CLK(sck), .SERIAL_DATA(sdi), .LATCH_STROBE(latch_strobe), .CHIP_ID_PIN_BIT0(id[0]),
      .CHIP_ID_PIN_BIT1(id[1]), .CHIP_ID_PIN_BIT2(id[2]), .FAST_SWITCH_SELECT(sel),
      .STAGE_CONTROL(stage));
   spi_host_model u_host (.clk(ref_clk), .sck(sck), .sdi(sdi), .latch_strobe(latch_strobe));
   task automatic check(input logic [6:0] seen, input logic [6:0] want);
      n_compared++;
      if (seen !== want)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   // only real changes are queued, since the monitor wakes on a change
   task automatic note(input logic [6:0] w);
      if (w !== cur)
         exp_q.push_back(w);
      cur = w;
   endtask : note
   task automatic wr(input logic [3:0] rg, input logic [7:0] d, input logic [6:0] w);
      note(w);
      u_host.send(rg, 1'b0, id, d);
      repeat (12) @(posedge ref_clk);
   endtask : wr
   task automatic pin(input logic s, input logic [6:0] w);
      note(w);
      sel <= s;
      repeat (12) @(posedge ref_clk);
   endtask : pin
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   always @(stage)
      if (mon_on)
         check(stage, exp_q.size() > 0 ? exp_q.pop_front() : ~stage);
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      test_done();
   end
   initial
   begin
      seed = 32'h2a1dabbd;
      reset = 1'b1;
      sel = 1'b0;
      id = FLOAT_CHIP_ID;
      mon_on = 1'b0;
      cur = 7'h7f;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4) @(posedge ref_clk);
      mon_on = 1'b1;
      check(stage, 7'h7f);
      wr(REG_PRIMARY, 8'h80, 7'h00);
      for (int i = 0; i < 10; i++)
      begin
         id <= 3'($random(seed));
         v = (i < 7) ? (7'h01 << i) : 7'($random(seed));
         @(posedge ref_clk);
         wr(REG_PRIMARY, {1'($random(seed)), v}, v);
      end
      $display("stage words done");
      u_host.send(REG_PRIMARY, 1'b0, ~id, 8'h15);
      u_host.send(REG_PRIMARY, 1'b1, id, 8'h15);
      pin(1'b1, v);
      wr(REG_CONFIG, 8'h02, 7'h7f);
      wr(REG_PRESET, 8'h2a, 7'h2a);
      pin(1'b0, v);
      pin(1'b1, 7'h2a);
      wr(REG_CONFIG, 8'h00, v);
      wr(REG_CONFIG, 8'h02, 7'h2a);
      wr(REG_CONFIG, 8'h03, v);
      wr(REG_CONFIG, 8'h02, 7'h2a);
      $display("fast switch done");
      note(7'h7f);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (4) @(posedge ref_clk);
      wr(REG_PRIMARY, 8'h11, 7'h11);
      check(7'(exp_q.size()), 7'h00);
      $display("reset done");
      test_done();
   end
endmodule : tb_step_attenuator_serial_control
